// ### src/spm_part_eval.sv
// Membership evaluator for one partition: finds its upstream port and whether it has downstream ports.
`timescale 1ns/1ps
module spm_part_eval #(
    parameter int NUM_PORTS = 16,
    parameter int PIDW = 4,
    parameter logic [3:0] PART_ID = 4'h0
) (
    // Effective port modes and partition selects
    input wire logic [NUM_PORTS-1:0][1:0] eff_mode,
    input wire logic [NUM_PORTS-1:0][3:0] part_sel,
    // Summary
    spm_part_if.eval res
);
    // Only the ports that select this partition are looked at, so other partitions never see
    // a mode change that does not concern them.
    always_comb begin
        res.us_present = 1'b0;
        res.ds_present = 1'b0;
        res.us_id = '0;
        for (int i = NUM_PORTS - 1; i >= 0; i--) begin
            if (part_sel[i] == PART_ID) begin
                if (eff_mode[i] == spm_pkg::MODE_UPSTREAM) begin
                    res.us_present = 1'b1;
                    res.us_id = PIDW'(i);
                end
                if (eff_mode[i] == spm_pkg::MODE_DOWNSTREAM) begin
                    res.ds_present = 1'b1;
                end
            end
        end
    end
endmodule : spm_part_eval

// ### src/spm_part_if.sv
// Per-partition membership summary carried from evaluator to manager.
`timescale 1ns/1ps
interface spm_part_if #(
    parameter int PIDW = 4
);
    logic us_present;
    logic ds_present;
    logic [PIDW-1:0] us_id;
    modport eval (output us_present, output ds_present, output us_id);
    modport sink (input us_present, input ds_present, input us_id);
endinterface : spm_part_if

// ### src/spm_pkg.sv
// Constants shared by the switch partition manager files.
package spm_pkg;
    // Port mode field encodings.
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] MODE_DOWNSTREAM = 2'h1;
    localparam logic [1:0] MODE_UPSTREAM = 2'h2;
    localparam logic [1:0] MODE_UNATTACHED = 2'h3;
    // Partition state field encodings; the fourth code is refused.
    localparam logic [1:0] PSTATE_DISABLED = 2'h0;
    localparam logic [1:0] PSTATE_FUND_RESET = 2'h1;
    localparam logic [1:0] PSTATE_ACTIVE = 2'h2;
    localparam int PART_ID_W = 4;
    localparam int NUM_PARTS_MAX = 16;
    // Register regions; the word index sits in paddr[7:2].
    localparam logic [3:0] REGION_PORT_CTL = 4'h0;
    localparam logic [3:0] REGION_PART_CTL = 4'h1;
    localparam logic [3:0] REGION_PART_STS = 4'h2;
    // Port control fields.
    localparam int PCTL_MODE_LSB = 0;
    localparam int PCTL_SEL_LSB = 8;
    localparam int PCTL_EFF_MODE_LSB = 16;
    localparam int PCTL_ATTACHED_BIT = 18;
    // Partition control fields.
    localparam int PART_STATE_LSB = 0;
    localparam int PART_HRLD_BIT = 2;
    // Partition status fields.
    localparam int STS_US_PRESENT_BIT = 0;
    localparam int STS_DS_PRESENT_BIT = 1;
    localparam int STS_IN_RESET_BIT = 2;
    localparam int STS_US_ID_LSB = 8;
    // Values after reset.
    localparam logic [1:0] RST_PORT_MODE = MODE_UNATTACHED;
    localparam logic [3:0] RST_PART_SEL = 4'h0;
    localparam logic [1:0] RST_PART_STATE = PSTATE_DISABLED;
    localparam logic RST_HRLD = 1'b0;
endpackage : spm_pkg

// ### src/spm_switch_partition_manager.sv
// Switch partition manager: port attachment, partition state and per-partition routing policy.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module spm_switch_partition_manager #(
    parameter int NUM_PORTS = 16,
    parameter int NUM_PARTS = 16
) (
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Per-port attachment
    output logic [NUM_PORTS-1:0][1:0] port_eff_mode,
    output logic [NUM_PORTS-1:0] port_attached,
    output logic [NUM_PORTS-1:0] port_in_reset,
    // Per-partition state and routing policy
    output logic [NUM_PARTS-1:0] part_active,
    output logic [NUM_PARTS-1:0] part_in_reset,
    output logic [NUM_PARTS-1:0] part_std_switch,
    output logic [NUM_PARTS-1:0] part_ur_req_but_cfg,
    output logic [NUM_PARTS-1:0] part_ur_cpl,
    output logic [NUM_PARTS-1:0] part_us_aspm_free,
    output logic [NUM_PARTS-1:0] part_ds_hot_reset,
    output logic [NUM_PARTS-1:0] part_p2p_forward,
    output logic [NUM_PARTS-1:0] part_ur_not_ds,
    output logic [NUM_PARTS-1:0] part_drop_root_tlp,
    output logic [NUM_PARTS-1:0] part_ds_aspm_free
);
    localparam int PIDW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

    // Programmed state.
    logic [NUM_PORTS-1:0][1:0] mode_q;
    logic [NUM_PORTS-1:0][3:0] sel_q;
    logic [NUM_PARTS-1:0][1:0] pstate_q;
    logic [NUM_PARTS-1:0] hrld_q;

    // APB registers.
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    // Output registers.
    logic [NUM_PORTS-1:0][1:0] port_eff_mode_q;
    logic [NUM_PORTS-1:0] port_attached_q;
    logic [NUM_PORTS-1:0] port_in_reset_q;
    logic [NUM_PARTS-1:0] part_active_q;
    logic [NUM_PARTS-1:0] part_in_reset_q;
    logic [NUM_PARTS-1:0] part_std_switch_q;
    logic [NUM_PARTS-1:0] part_ur_req_but_cfg_q;
    logic [NUM_PARTS-1:0] part_ur_cpl_q;
    logic [NUM_PARTS-1:0] part_us_aspm_free_q;
    logic [NUM_PARTS-1:0] part_ds_hot_reset_q;
    logic [NUM_PARTS-1:0] part_p2p_forward_q;
    logic [NUM_PARTS-1:0] part_ur_not_ds_q;
    logic [NUM_PARTS-1:0] part_drop_root_tlp_q;
    logic [NUM_PARTS-1:0] part_ds_aspm_free_q;

    // Combinational state.
    logic [NUM_PORTS-1:0][1:0] eff_mode_d;
    logic [NUM_PORTS-1:0] attached_d;
    logic [NUM_PORTS-1:0] port_in_reset_d;
    logic [NUM_PARTS-1:0] us_present;
    logic [NUM_PARTS-1:0] ds_present;
    logic [NUM_PARTS-1:0][PIDW-1:0] us_id;
    logic [NUM_PARTS-1:0] pol_std_d;
    logic [NUM_PARTS-1:0] pol_us_only_d;
    logic [NUM_PARTS-1:0] pol_no_us_d;
    logic access_setup;
    logic access_commit;
    logic hit;
    logic [31:0] rd_data;
    logic [3:0] region;
    logic [5:0] word_idx;

    // Partition state selected by a port; a select beyond the built partitions reads disabled.
    function automatic logic [1:0] sel_state(input logic [3:0] sel,
                                             input logic [NUM_PARTS-1:0][1:0] st);
        logic [1:0] r;
        r = spm_pkg::PSTATE_DISABLED;
        for (int p = 0; p < NUM_PARTS; p++) begin
            if (sel == 4'(p)) begin
                r = st[p];
            end
        end
        return r;
    endfunction : sel_state

    // Effective port mode and attachment.
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            logic operational;
            logic [1:0] st;
            operational = (mode_q[i] == spm_pkg::MODE_UPSTREAM) ||
                          (mode_q[i] == spm_pkg::MODE_DOWNSTREAM);
            st = sel_state(sel_q[i], pstate_q);
            if (operational && st == spm_pkg::PSTATE_DISABLED) begin
                eff_mode_d[i] = spm_pkg::MODE_DISABLED;
            end else begin
                eff_mode_d[i] = mode_q[i];
            end
            attached_d[i] = operational && st != spm_pkg::PSTATE_DISABLED;
            port_in_reset_d[i] = attached_d[i] && st == spm_pkg::PSTATE_FUND_RESET;
        end
    end

    // One evaluator per partition.
    generate
        for (genvar p = 0; p < NUM_PARTS; p++) begin : g_part
            spm_part_if #(.PIDW(PIDW)) sum_if ();
            spm_part_eval #(
                .NUM_PORTS(NUM_PORTS),
                .PIDW(PIDW),
                .PART_ID(4'(p))
            ) u_eval (
                .eff_mode(eff_mode_d),
                .part_sel(sel_q),
                .res(sum_if.eval)
            );
            assign us_present[p] = sum_if.us_present;
            assign ds_present[p] = sum_if.ds_present;
            assign us_id[p] = sum_if.us_id;
        end
    endgenerate

    // Routing policy; an empty or non-active partition asserts nothing.
    always_comb begin
        for (int p = 0; p < NUM_PARTS; p++) begin
            logic act;
            act = pstate_q[p] == spm_pkg::PSTATE_ACTIVE;
            pol_std_d[p] = act && us_present[p] && ds_present[p];
            pol_us_only_d[p] = act && us_present[p] && !ds_present[p];
            pol_no_us_d[p] = act && !us_present[p] && ds_present[p];
        end
    end

    // APB decode.
    assign access_setup = psel && penable && !pready_q;
    assign access_commit = psel && penable && pready_q;
    assign region = paddr[11:8];
    assign word_idx = paddr[7:2];

    always_comb begin
        hit = 1'b0;
        rd_data = 32'h00000000;
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (region == spm_pkg::REGION_PORT_CTL && 32'(word_idx) < NUM_PORTS) begin
            hit = 1'b1;
            for (int i = 0; i < NUM_PORTS; i++) begin
                if (word_idx == 6'(i)) begin
                    rd_data[spm_pkg::PCTL_MODE_LSB +: 2] = mode_q[i];
                    rd_data[spm_pkg::PCTL_SEL_LSB +: 4] = sel_q[i];
                    rd_data[spm_pkg::PCTL_EFF_MODE_LSB +: 2] = eff_mode_d[i];
                    rd_data[spm_pkg::PCTL_ATTACHED_BIT] = attached_d[i];
                end
            end
        end else if (region == spm_pkg::REGION_PART_CTL && 32'(word_idx) < NUM_PARTS) begin
            hit = 1'b1;
            for (int p = 0; p < NUM_PARTS; p++) begin
                if (word_idx == 6'(p)) begin
                    rd_data[spm_pkg::PART_STATE_LSB +: 2] = pstate_q[p];
                    rd_data[spm_pkg::PART_HRLD_BIT] = hrld_q[p];
                end
            end
        end else if (region == spm_pkg::REGION_PART_STS && 32'(word_idx) < NUM_PARTS) begin
            hit = 1'b1;
            for (int p = 0; p < NUM_PARTS; p++) begin
                if (word_idx == 6'(p)) begin
                    rd_data[spm_pkg::STS_US_PRESENT_BIT] = us_present[p];
                    rd_data[spm_pkg::STS_DS_PRESENT_BIT] = ds_present[p];
                    rd_data[spm_pkg::STS_IN_RESET_BIT] =
                        pstate_q[p] == spm_pkg::PSTATE_FUND_RESET;
                    rd_data[spm_pkg::STS_US_ID_LSB +: PIDW] = us_id[p];
                end
            end
        end
    end

    // One wait state: pready rises in the cycle after setup, data is sampled with it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (ce) begin
            pready_q <= access_setup;
            pslverr_q <= access_setup && !hit;
            if (access_setup && !pwrite) begin
                prdata_q <= hit ? rd_data : 32'h00000000;
            end
        end
    end

    // Port control writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                mode_q[i] <= spm_pkg::RST_PORT_MODE;
                sel_q[i] <= spm_pkg::RST_PART_SEL;
            end
        end else if (ce && access_commit && pwrite && !pslverr_q &&
                     region == spm_pkg::REGION_PORT_CTL) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                if (word_idx == 6'(i)) begin
                    mode_q[i] <= pwdata[spm_pkg::PCTL_MODE_LSB +: 2];
                    sel_q[i] <= pwdata[spm_pkg::PCTL_SEL_LSB +: 4];
                end
            end
        end
    end

    // Partition control writes; the reserved state code is refused and the old state kept,
    // since the hardware cannot guard other illegal transitions and leaves them to software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NUM_PARTS; p++) begin
                pstate_q[p] <= spm_pkg::RST_PART_STATE;
                hrld_q[p] <= spm_pkg::RST_HRLD;
            end
        end else if (ce && access_commit && pwrite && !pslverr_q &&
                     region == spm_pkg::REGION_PART_CTL) begin
            for (int p = 0; p < NUM_PARTS; p++) begin
                if (word_idx == 6'(p)) begin
                    if (pwdata[spm_pkg::PART_STATE_LSB +: 2] != 2'h3) begin
                        pstate_q[p] <= pwdata[spm_pkg::PART_STATE_LSB +: 2];
                    end
                    if (pwdata[spm_pkg::PART_STATE_LSB +: 2] == spm_pkg::PSTATE_FUND_RESET &&
                        pstate_q[p] != spm_pkg::PSTATE_FUND_RESET) begin
                        hrld_q[p] <= spm_pkg::RST_HRLD;
                    end else begin
                        hrld_q[p] <= pwdata[spm_pkg::PART_HRLD_BIT];
                    end
                end
            end
        end
    end

    // Port side outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_eff_mode_q <= '0;
            port_attached_q <= '0;
            port_in_reset_q <= '0;
        end else if (ce) begin
            port_eff_mode_q <= eff_mode_d;
            port_attached_q <= attached_d;
            port_in_reset_q <= port_in_reset_d;
        end
    end

    // Partition side outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            part_active_q <= '0;
            part_in_reset_q <= '0;
            part_std_switch_q <= '0;
            part_ur_req_but_cfg_q <= '0;
            part_ur_cpl_q <= '0;
            part_us_aspm_free_q <= '0;
            part_ds_hot_reset_q <= '0;
            part_p2p_forward_q <= '0;
            part_ur_not_ds_q <= '0;
            part_drop_root_tlp_q <= '0;
            part_ds_aspm_free_q <= '0;
        end else if (ce) begin
            for (int p = 0; p < NUM_PARTS; p++) begin
                part_active_q[p] <= pstate_q[p] == spm_pkg::PSTATE_ACTIVE;
                part_in_reset_q[p] <= pstate_q[p] == spm_pkg::PSTATE_FUND_RESET;
            end
            part_std_switch_q <= pol_std_d;
            part_ur_req_but_cfg_q <= pol_us_only_d;
            part_ur_cpl_q <= pol_us_only_d;
            part_us_aspm_free_q <= pol_us_only_d;
            part_ds_hot_reset_q <= pol_no_us_d;
            part_p2p_forward_q <= pol_no_us_d | pol_std_d;
            part_ur_not_ds_q <= pol_no_us_d;
            part_drop_root_tlp_q <= pol_no_us_d;
            part_ds_aspm_free_q <= pol_no_us_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign port_eff_mode = port_eff_mode_q;
    assign port_attached = port_attached_q;
    assign port_in_reset = port_in_reset_q;
    assign part_active = part_active_q;
    assign part_in_reset = part_in_reset_q;
    assign part_std_switch = part_std_switch_q;
    assign part_ur_req_but_cfg = part_ur_req_but_cfg_q;
    assign part_ur_cpl = part_ur_cpl_q;
    assign part_us_aspm_free = part_us_aspm_free_q;
    assign part_ds_hot_reset = part_ds_hot_reset_q;
    assign part_p2p_forward = part_p2p_forward_q;
    assign part_ur_not_ds = part_ur_not_ds_q;
    assign part_drop_root_tlp = part_drop_root_tlp_q;
    assign part_ds_aspm_free = part_ds_aspm_free_q;
endmodule : spm_switch_partition_manager

// ### verification/spm_mgmt_master.sv
// Management master model that programs the block over APB.
`timescale 1ns/1ps
module spm_mgmt_master (
    // Clock
    input wire logic pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // The leading edge keeps two transfers from driving psel in one time step.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A released data bus no longer shows the last word.
        pwdata <= ~d;
    endtask : xfer
endmodule : spm_mgmt_master

// ### verification/spm_switch_partition_manager_asserts.sv
// Port-level checker for the switch partition manager.
`timescale 1ns/1ps
module spm_switch_partition_manager_asserts #(
    parameter int NUM_PORTS = 16,
    parameter int NUM_PARTS = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Ports
    input wire logic [NUM_PORTS-1:0][1:0] port_eff_mode,
    input wire logic [NUM_PORTS-1:0] port_attached,
    input wire logic [NUM_PORTS-1:0] port_in_reset,
    // Partitions
    input wire logic [NUM_PARTS-1:0] part_active,
    input wire logic [NUM_PARTS-1:0] part_in_reset,
    input wire logic [NUM_PARTS-1:0] part_std_switch,
    input wire logic [NUM_PARTS-1:0] part_ur_req_but_cfg,
    input wire logic [NUM_PARTS-1:0] part_ur_cpl,
    input wire logic [NUM_PARTS-1:0] part_us_aspm_free,
    input wire logic [NUM_PARTS-1:0] part_ds_hot_reset,
    input wire logic [NUM_PARTS-1:0] part_p2p_forward,
    input wire logic [NUM_PARTS-1:0] part_ur_not_ds,
    input wire logic [NUM_PARTS-1:0] part_drop_root_tlp,
    input wire logic [NUM_PARTS-1:0] part_ds_aspm_free
);
    logic attach_bad;
    // An attached port must show an operational mode, whatever its partition does.
    always_comb begin
        attach_bad = 1'b0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (port_attached[i] && port_eff_mode[i] != spm_pkg::MODE_DOWNSTREAM &&
                port_eff_mode[i] != spm_pkg::MODE_UPSTREAM) begin
                attach_bad = 1'b1;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_wait; psel && penable && !pready |=> pready; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready late");
    property p_ready_idle; !(psel && penable) |=> !pready; endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("pready without access");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_err_with_ready; pslverr |-> pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr alone");
    property p_attach_mode; !attach_bad; endproperty
    a_attach_mode: assert property (p_attach_mode) else $error("attached port mode");
    property p_reset_attached; (port_in_reset & ~port_attached) == '0; endproperty
    a_reset_attached: assert property (p_reset_attached) else $error("reset unattached");
    property p_state_excl; (part_active & part_in_reset) == '0; endproperty
    a_state_excl: assert property (p_state_excl) else $error("two states");
    property p_policy_active;
        ((part_p2p_forward | part_ur_cpl | part_ds_hot_reset) & ~part_active) == '0;
    endproperty
    a_policy_active: assert property (p_policy_active) else $error("policy off state");
    property p_us_only;
        part_ur_req_but_cfg == part_ur_cpl && part_ur_cpl == part_us_aspm_free;
    endproperty
    a_us_only: assert property (p_us_only) else $error("upstream-only split");
    property p_no_us;
        part_ds_hot_reset == part_ur_not_ds && part_ur_not_ds == part_drop_root_tlp &&
            part_drop_root_tlp == part_ds_aspm_free;
    endproperty
    a_no_us: assert property (p_no_us) else $error("no-upstream split");
    property p_p2p; part_p2p_forward == (part_std_switch | part_ds_hot_reset); endproperty
    a_p2p: assert property (p_p2p) else $error("peer forward");
    property p_kind_excl;
        ((part_std_switch & part_ur_cpl) | (part_ur_cpl & part_ds_hot_reset)) == '0;
    endproperty
    a_kind_excl: assert property (p_kind_excl) else $error("two kinds");
    c_std: cover property (part_std_switch != '0);
    c_us_only: cover property (part_ur_cpl != '0);
    c_no_us: cover property (part_ds_hot_reset != '0);
    c_err: cover property (pslverr);
endmodule : spm_switch_partition_manager_asserts
bind spm_switch_partition_manager spm_switch_partition_manager_asserts #(
    .NUM_PORTS(NUM_PORTS), .NUM_PARTS(NUM_PARTS)) chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .port_eff_mode(port_eff_mode), .port_attached(port_attached),
    .port_in_reset(port_in_reset), .part_active(part_active), .part_in_reset(part_in_reset),
    .part_std_switch(part_std_switch), .part_ur_req_but_cfg(part_ur_req_but_cfg),
    .part_ur_cpl(part_ur_cpl), .part_us_aspm_free(part_us_aspm_free),
    .part_ds_hot_reset(part_ds_hot_reset), .part_p2p_forward(part_p2p_forward),
    .part_ur_not_ds(part_ur_not_ds), .part_drop_root_tlp(part_drop_root_tlp),
    .part_ds_aspm_free(part_ds_aspm_free));

// ### verification/spm_switch_partition_manager_test.sv
// Self-checking testbench for the switch partition manager.
`timescale 1ns/1ps
module spm_switch_partition_manager_test;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0][1:0] port_eff_mode;
    logic [15:0] port_attached, port_in_reset, part_active, part_in_reset, part_std_switch;
    logic [15:0] part_ur_req_but_cfg, part_ur_cpl, part_us_aspm_free, part_ds_hot_reset;
    logic [15:0] part_p2p_forward, part_ur_not_ds, part_drop_root_tlp, part_ds_aspm_free;
    int bad_count, n_compared, cycles;
    spm_switch_partition_manager dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .port_eff_mode, .port_attached,
        .port_in_reset, .part_active, .part_in_reset, .part_std_switch, .part_ur_req_but_cfg,
        .part_ur_cpl, .part_us_aspm_free, .part_ds_hot_reset, .part_p2p_forward,
        .part_ur_not_ds, .part_drop_root_tlp, .part_ds_aspm_free);
    spm_mgmt_master mst_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    // The whole run needs well under a thousand cycles.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        mst_u.xfer(1'b1, a, d, rdat, err);
        chk("write error", 32'h0, {31'h0, err});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        mst_u.xfer(1'b0, a, 32'h0, rdat, err);
        chk(what, exp, rdat);
    endtask : rd
    function automatic logic [31:0] pctl(input logic [1:0] m, input logic [3:0] s);
        return {20'h0, s, 6'h0, m};
    endfunction : pctl
    task automatic settle;
        repeat (3) @(posedge pclk);
        #1;
    endtask : settle
    task automatic t_reset;
        settle();
        rd(12'h000, 32'h0003_0003, "port0 ctl");
        rd(12'h100, 32'h0, "part0 ctl");
        rd(12'h200, 32'h0, "part0 sts");
        chk("attached", 32'h0, {16'h0, port_attached});
    endtask : t_reset
    task automatic t_std;
        wr(12'h00C, pctl(spm_pkg::MODE_UPSTREAM, 4'h5));
        wr(12'h010, pctl(spm_pkg::MODE_DOWNSTREAM, 4'h5));
        wr(12'h018, pctl(spm_pkg::MODE_DOWNSTREAM, 4'h5));
        settle();
        chk("port3 mode", {30'h0, spm_pkg::MODE_DISABLED}, {30'h0, port_eff_mode[3]});
        wr(12'h114, {30'h0, spm_pkg::PSTATE_ACTIVE});
        settle();
        chk("attached", 32'h0058, {16'h0, port_attached});
        chk("port3 mode", {30'h0, spm_pkg::MODE_UPSTREAM}, {30'h0, port_eff_mode[3]});
        rd(12'h214, 32'h0000_0303, "part5 sts");
        chk("std switch", 32'h0020, {16'h0, part_std_switch});
        chk("active", 32'h0020, {16'h0, part_active});
    endtask : t_std
    task automatic t_us_only;
        wr(12'h03C, pctl(spm_pkg::MODE_UPSTREAM, 4'hF));
        wr(12'h13C, {30'h0, spm_pkg::PSTATE_ACTIVE});
        wr(12'h124, {30'h0, spm_pkg::PSTATE_ACTIVE});
        settle();
        chk("ur req", 32'h8000, {16'h0, part_ur_req_but_cfg});
        chk("ur cpl", 32'h8000, {16'h0, part_ur_cpl});
        chk("us aspm", 32'h8000, {16'h0, part_us_aspm_free});
        chk("p2p", 32'h0020, {16'h0, part_p2p_forward});
        chk("active", 32'h8220, {16'h0, part_active});
    endtask : t_us_only
    task automatic t_no_us;
        wr(12'h000, pctl(spm_pkg::MODE_DOWNSTREAM, 4'h0));
        wr(12'h004, pctl(spm_pkg::MODE_DOWNSTREAM, 4'h0));
        wr(12'h100, {30'h0, spm_pkg::PSTATE_ACTIVE});
        settle();
        chk("hot reset", 32'h0001, {16'h0, part_ds_hot_reset});
        chk("p2p", 32'h0021, {16'h0, part_p2p_forward});
        chk("ur not ds", 32'h0001, {16'h0, part_ur_not_ds});
        chk("drop root", 32'h0001, {16'h0, part_drop_root_tlp});
        chk("ds aspm", 32'h0001, {16'h0, part_ds_aspm_free});
        wr(12'h008, pctl(spm_pkg::MODE_UPSTREAM, 4'h0));
        settle();
        rd(12'h200, 32'h0000_0203, "part0 sts");
        chk("std switch", 32'h0021, {16'h0, part_std_switch});
        wr(12'h008, pctl(spm_pkg::MODE_UNATTACHED, 4'h0));
        wr(12'h01C, pctl(spm_pkg::MODE_UNATTACHED, 4'h5));
        settle();
        rd(12'h200, 32'h0000_0002, "part0 sts");
        chk("std switch", 32'h0020, {16'h0, part_std_switch});
        chk("attached", 32'h805B, {16'h0, port_attached});
    endtask : t_no_us
    task automatic t_states;
        wr(12'h114, {29'h0, 1'b1, spm_pkg::PSTATE_FUND_RESET});
        settle();
        rd(12'h114, {30'h0, spm_pkg::PSTATE_FUND_RESET}, "part5 ctl");
        chk("part reset", 32'h0020, {16'h0, part_in_reset});
        chk("port reset", 32'h0058, {16'h0, port_in_reset});
        chk("std switch", 32'h0, {16'h0, part_std_switch});
        wr(12'h114, {30'h0, spm_pkg::PSTATE_ACTIVE});
        wr(12'h114, 32'h0000_0003);
        rd(12'h114, {30'h0, spm_pkg::PSTATE_ACTIVE}, "part5 ctl");
        wr(12'h114, {30'h0, spm_pkg::PSTATE_DISABLED});
        ce <= 1'b0;
        settle();
        chk("frozen mode", {30'h0, spm_pkg::MODE_DOWNSTREAM}, {30'h0, port_eff_mode[4]});
        @(posedge pclk);
        ce <= 1'b1;
        settle();
        chk("port4 mode", {30'h0, spm_pkg::MODE_DISABLED}, {30'h0, port_eff_mode[4]});
        chk("attached", 32'h8003, {16'h0, port_attached});
    endtask : t_states
    task automatic t_apb_err;
        mst_u.xfer(1'b0, 12'h300, 32'h0, rdat, err);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rdat);
        mst_u.xfer(1'b1, 12'h102, 32'h0000_0002, rdat, err);
        chk("misaligned err", 32'h1, {31'h0, err});
        wr(12'h200, 32'hFFFF_FFFF);
        rd(12'h200, 32'h0000_0002, "part0 sts");
    endtask : t_apb_err
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        bad_count = 0;
        n_compared = 0;
        cycles = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_std();
        t_us_only();
        t_no_us();
        t_states();
        t_apb_err();
        end_of_test();
    end
endmodule : spm_switch_partition_manager_test
